// >>> src/pvc_pkg.sv
package pvc_pkg;
	// register offsets on the microport
	localparam logic [3:0] PVC_OFS_GAIN_ONE = 4'h0;
	localparam logic [3:0] PVC_OFS_GAIN_TWO = 4'h1;
	localparam logic [3:0] PVC_OFS_CODING = 4'h4;
	// reset values: gains 0 dB, side-tone off, mu-law, standard code, strobed mode, powered up
	localparam logic [7:0] PVC_RST_GAIN_ONE = 8'h00;
	localparam logic [7:0] PVC_RST_GAIN_TWO = 8'h00;
	localparam logic [7:0] PVC_RST_CODING = 8'h00;
	// gain_control_one fields
	localparam int PVC_TXFG_LSB = 0;
	localparam int PVC_RXFG_LSB = 3;
	// gain_control_two fields
	localparam int PVC_STG_LSB = 0;
	localparam int PVC_ST_EN_BIT = 3;
	// coding_control fields
	localparam int PVC_LAW_BIT = 0;
	localparam int PVC_SMAG_BIT = 1;
	localparam int PVC_BPMODE_BIT = 2;
	localparam int PVC_PWRDN_BIT = 3;
	// microport command byte
	localparam int PVC_CMD_READ_BIT = 7;
	localparam logic [4:0] PVC_MP_CMD_BITS = 5'h08;
	localparam logic [4:0] PVC_MP_ALL_BITS = 5'h10;
	// code conversion masks applied to sign-magnitude samples
	localparam logic [7:0] PVC_MASK_MU = 8'h7f;
	localparam logic [7:0] PVC_MASK_A = 8'h55;
	localparam logic [7:0] PVC_MASK_SMAG = 8'h00;
	// serial link timing in bit periods
	localparam int PVC_WORD_BITS = 8;
	localparam int PVC_CASCADE_SLOTS = 4;
	localparam int PVC_DLY_FP_BIT = PVC_CASCADE_SLOTS * PVC_WORD_BITS - 1;
	localparam int PVC_DLY_STB_FIRST = PVC_WORD_BITS;
	localparam int PVC_DLY_STB_LAST = 2 * PVC_WORD_BITS - 1;
	localparam int PVC_SYNC_STAGES = 2;
endpackage

// >>> src/pvc_sync.sv
`timescale 1ns/100ps
module pvc_sync
#(
	parameter int WIDTH = 1
)
(
	input wire logic i_clk, // destination clock
	input wire logic i_reset_n, // asynchronous reset, active low
	input wire logic [WIDTH-1:0] i_async, // signal from another domain
	output logic [WIDTH-1:0] o_sync // synchronised copy
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] meta_nxt;
	logic [WIDTH-1:0] sync_r;
	logic [WIDTH-1:0] sync_nxt;

	always_comb
	begin
		meta_nxt = i_async;
		sync_nxt = meta_r;
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			meta_r <= '0;
			sync_r <= '0;
		end
		else
		begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign o_sync = sync_r;
endmodule

// >>> src/pvc_code_map.sv
`timescale 1ns/100ps
module pvc_code_map
	import pvc_pkg::*;
(
	input wire logic i_a_law, // a-law selected
	input wire logic i_sign_mag, // sign-magnitude coding selected
	input wire logic [7:0] i_code, // code in
	output logic [7:0] o_code // code out
);
	// the mapping is an xor, so the same function converts both ways
	function automatic logic [7:0] map_code(input logic a_law, input logic smag, input logic [7:0] code);
		logic [7:0] mask;
		mask = smag ? PVC_MASK_SMAG : (a_law ? PVC_MASK_A : PVC_MASK_MU);
		return code ^ mask;
	endfunction

	always_comb
	begin
		o_code = map_code(i_a_law, i_sign_mag, i_code);
	end
endmodule

// >>> src/pvc_digital_port.sv
`timescale 1ns/100ps
module pvc_digital_port
	import pvc_pkg::*;
#(
	parameter int CNT_W = 9
)
(
	input wire logic i_sys_clk, // system clock, 25 MHz
	input wire logic i_reset_n, // power_up_reset_n, asynchronous
	input wire logic i_link_clk, // bit clock / master_clock_in of the link
	input wire logic i_slot_strobe_frame_in, // strobe (strobed) or frame pulse (backplane)
	input wire logic i_din, // serial receive data
	output logic o_dout, // serial transmit data
	output logic o_dout_oe, // transmit data drive enable
	output logic o_delayed_strobe_out, // cascade strobe or frame pulse
	input wire logic i_law_pin, // shared pin, law input side
	output logic o_law_pin_out, // shared pin, open-drain output level
	output logic o_law_pin_oe, // shared pin, drive enable
	input wire logic i_cs_n, // microport chip select, active low
	input wire logic i_sclk, // microport clock
	input wire logic i_data2, // microport receive data
	output logic o_data1, // microport transmit data
	output logic o_data1_oe, // microport transmit enable
	input wire logic [7:0] i_tx_sample, // sign-magnitude sample from the converter
	output logic [7:0] o_rx_sample, // sign-magnitude sample to the converter
	output logic o_rx_valid, // pulse: new receive sample
	output logic [2:0] o_tx_filter_gain, // transmit filter gain steps
	output logic [2:0] o_rx_filter_gain, // receive filter attenuation steps
	output logic [2:0] o_sidetone_gain, // side-tone gain code
	output logic o_sidetone_en, // side-tone path enable
	output logic o_codec_power_up, // filter_codec_section powered
	output logic o_a_law // a-law companding in use
);
	if (CNT_W < 6)
		$error("CNT_W too small for the cascade delay");

	localparam logic [CNT_W-1:0] CNT_MAX = '1;
	localparam logic [CNT_W-1:0] CNT_WORD = CNT_W'(PVC_WORD_BITS);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PVC_WORD_BITS - 1);
	localparam logic [CNT_W-1:0] CNT_DFP = CNT_W'(PVC_DLY_FP_BIT);
	localparam logic [CNT_W-1:0] CNT_DS0 = CNT_W'(PVC_DLY_STB_FIRST);
	localparam logic [CNT_W-1:0] CNT_DS1 = CNT_W'(PVC_DLY_STB_LAST);

	typedef enum logic [1:0] {MP_IDLE, MP_CMD, MP_DATA, MP_WAIT} pvc_mp_e;

	// ---------------- system domain: registers and microport ----------------
	logic [7:0] gain_one_r, gain_one_nxt;
	logic [7:0] gain_two_r, gain_two_nxt;
	logic [7:0] coding_r, coding_nxt;
	pvc_mp_e mp_state_r, mp_state_nxt;
	logic [4:0] mp_cnt_r, mp_cnt_nxt;
	logic [7:0] mp_in_r, mp_in_nxt;
	logic [7:0] mp_cmd_r, mp_cmd_nxt;
	logic [7:0] mp_out_r, mp_out_nxt;
	logic data1_r, data1_nxt;
	logic data1_oe_r, data1_oe_nxt;
	logic sclk_prev_r, sclk_prev_nxt;
	logic cs_prev_r, cs_prev_nxt;
	logic [2:0] mp_sync;
	logic law_pin_s;
	logic mp_cs_n, mp_sclk, mp_d2;
	logic sclk_rise, sclk_fall;
	logic [7:0] shift_in;

	pvc_sync #(.WIDTH(3)) u_mp_sync (
		.i_clk(i_sys_clk),
		.i_reset_n(i_reset_n),
		.i_async({~i_cs_n, i_sclk, i_data2}), // select goes in inverted so its cleared state reads idle
		.o_sync(mp_sync)
	);

	pvc_sync #(.WIDTH(1)) u_law_sync (
		.i_clk(i_sys_clk),
		.i_reset_n(i_reset_n),
		.i_async(i_law_pin),
		.o_sync(law_pin_s)
	);

	assign mp_cs_n = !mp_sync[2];
	assign mp_sclk = mp_sync[1];
	assign mp_d2 = mp_sync[0];
	assign sclk_rise = mp_sclk && !sclk_prev_r;
	assign sclk_fall = !mp_sclk && sclk_prev_r;
	assign shift_in = {mp_in_r[6:0], mp_d2};

	function automatic logic [7:0] reg_read(input logic [3:0] addr, input logic [7:0] g1, input logic [7:0] g2,
		input logic [7:0] cc);
		case (addr)
			PVC_OFS_GAIN_ONE: reg_read = g1;
			PVC_OFS_GAIN_TWO: reg_read = g2;
			PVC_OFS_CODING: reg_read = cc;
			default: reg_read = 8'h00;
		endcase
	endfunction

	always_comb
	begin
		gain_one_nxt = gain_one_r;
		gain_two_nxt = gain_two_r;
		coding_nxt = coding_r;
		mp_state_nxt = mp_state_r;
		mp_cnt_nxt = mp_cnt_r;
		mp_in_nxt = mp_in_r;
		mp_cmd_nxt = mp_cmd_r;
		mp_out_nxt = mp_out_r;
		data1_nxt = data1_r;
		data1_oe_nxt = data1_oe_r;
		sclk_prev_nxt = mp_sclk;
		cs_prev_nxt = mp_cs_n;
		if (mp_cs_n)
		begin
			mp_state_nxt = MP_IDLE;
			data1_oe_nxt = 1'b0;
		end
		else
		begin
			case (mp_state_r)
				MP_IDLE:
				begin
					if (cs_prev_r)
					begin
						mp_state_nxt = MP_CMD;
						mp_cnt_nxt = 5'h00;
					end
				end
				MP_CMD:
				begin
					if (sclk_rise)
					begin
						mp_in_nxt = shift_in;
						mp_cnt_nxt = mp_cnt_r + 5'h01;
						if (mp_cnt_r + 5'h01 == PVC_MP_CMD_BITS)
						begin
							mp_cmd_nxt = shift_in;
							mp_out_nxt = reg_read(shift_in[3:0], gain_one_r, gain_two_r, coding_r);
							mp_state_nxt = MP_DATA;
						end
					end
				end
				MP_DATA:
				begin
					if (sclk_fall && mp_cmd_r[PVC_CMD_READ_BIT])
					begin
						data1_nxt = mp_out_r[7];
						data1_oe_nxt = 1'b1;
						mp_out_nxt = {mp_out_r[6:0], 1'b0};
					end
					if (sclk_rise)
					begin
						mp_in_nxt = shift_in;
						mp_cnt_nxt = mp_cnt_r + 5'h01;
						if (mp_cnt_r + 5'h01 == PVC_MP_ALL_BITS)
						begin
							mp_state_nxt = MP_WAIT;
							if (!mp_cmd_r[PVC_CMD_READ_BIT])
							begin
								case (mp_cmd_r[3:0])
									PVC_OFS_GAIN_ONE: gain_one_nxt = shift_in;
									PVC_OFS_GAIN_TWO: gain_two_nxt = shift_in;
									PVC_OFS_CODING: coding_nxt = shift_in;
									default: ;
								endcase
							end
						end
					end
				end
				MP_WAIT:
				begin
					if (sclk_fall)
						data1_oe_nxt = 1'b0;
				end
				default: mp_state_nxt = MP_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			gain_one_r <= PVC_RST_GAIN_ONE;
			gain_two_r <= PVC_RST_GAIN_TWO;
			coding_r <= PVC_RST_CODING;
			mp_state_r <= MP_IDLE;
			mp_cnt_r <= 5'h00;
			mp_in_r <= 8'h00;
			mp_cmd_r <= 8'h00;
			mp_out_r <= 8'h00;
			data1_r <= 1'b0;
			data1_oe_r <= 1'b0;
			sclk_prev_r <= 1'b0;
			cs_prev_r <= 1'b1;
		end
		else
		begin
			gain_one_r <= gain_one_nxt;
			gain_two_r <= gain_two_nxt;
			coding_r <= coding_nxt;
			mp_state_r <= mp_state_nxt;
			mp_cnt_r <= mp_cnt_nxt;
			mp_in_r <= mp_in_nxt;
			mp_cmd_r <= mp_cmd_nxt;
			mp_out_r <= mp_out_nxt;
			data1_r <= data1_nxt;
			data1_oe_r <= data1_oe_nxt;
			sclk_prev_r <= sclk_prev_nxt;
			cs_prev_r <= cs_prev_nxt;
		end
	end

	// gain steps are plain binary counts of 1 dB (or 3.32 dB for side-tone)
	assign o_tx_filter_gain = gain_one_r[PVC_TXFG_LSB +: 3];
	assign o_rx_filter_gain = gain_one_r[PVC_RXFG_LSB +: 3];
	assign o_sidetone_gain = gain_two_r[PVC_STG_LSB +: 3];
	assign o_sidetone_en = gain_two_r[PVC_ST_EN_BIT];
	assign o_codec_power_up = !coding_r[PVC_PWRDN_BIT];
	assign o_data1 = data1_r;
	assign o_data1_oe = data1_oe_r;

	// shared pin: law input while the d-channel is off, otherwise an idle open-drain output
	logic dchannel_enable;
	logic a_law;
	assign dchannel_enable = 1'b0;
	assign a_law = coding_r[PVC_LAW_BIT] || (law_pin_s && !dchannel_enable);
	assign o_a_law = a_law;
	assign o_law_pin_out = 1'b0;
	assign o_law_pin_oe = 1'b0;

	// ---------------- sample exchange with the link domain ----------------
	logic [7:0] tx_code, rx_lin;
	logic [7:0] tx_hold_r, tx_hold_nxt;
	logic [7:0] rx_sample_r, rx_sample_nxt;
	logic rx_valid_r, rx_valid_nxt;
	logic done_seen_r, done_seen_nxt;
	logic done_s;
	logic done_tgl_r, done_tgl_nxt;
	logic [7:0] rx_word_r, rx_word_nxt;

	pvc_code_map u_tx_map (
		.i_a_law(a_law),
		.i_sign_mag(coding_r[PVC_SMAG_BIT]),
		.i_code(i_tx_sample),
		.o_code(tx_code)
	);

	pvc_code_map u_rx_map (
		.i_a_law(a_law),
		.i_sign_mag(coding_r[PVC_SMAG_BIT]),
		.i_code(rx_word_r),
		.o_code(rx_lin)
	);

	pvc_sync #(.WIDTH(1)) u_done_sync (
		.i_clk(i_sys_clk),
		.i_reset_n(i_reset_n),
		.i_async(done_tgl_r),
		.o_sync(done_s)
	);

	// rx_word_r and tx_hold_r each stay still for most of a frame around the toggle
	always_comb
	begin
		done_seen_nxt = done_s;
		rx_valid_nxt = done_s != done_seen_r;
		rx_sample_nxt = rx_sample_r;
		tx_hold_nxt = tx_hold_r;
		if (done_s != done_seen_r)
		begin
			rx_sample_nxt = rx_lin;
			tx_hold_nxt = tx_code;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			done_seen_r <= 1'b0;
			rx_valid_r <= 1'b0;
			rx_sample_r <= 8'h00;
			tx_hold_r <= PVC_MASK_MU;
		end
		else
		begin
			done_seen_r <= done_seen_nxt;
			rx_valid_r <= rx_valid_nxt;
			rx_sample_r <= rx_sample_nxt;
			tx_hold_r <= tx_hold_nxt;
		end
	end

	assign o_rx_sample = rx_sample_r;
	assign o_rx_valid = rx_valid_r;

	// ---------------- link domain ----------------
	logic bp_mode;
	logic strobe;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic [7:0] rx_shift_r, rx_shift_nxt;
	logic stb_prev_r, stb_prev_nxt;
	logic framed_r, framed_nxt;
	logic dly_r, dly_nxt;
	logic [CNT_W-1:0] rx_idx;
	logic rx_en;

	pvc_sync #(.WIDTH(1)) u_mode_sync (
		.i_clk(i_link_clk),
		.i_reset_n(i_reset_n),
		.i_async(coding_r[PVC_BPMODE_BIT]),
		.o_sync(bp_mode)
	);

	assign strobe = i_slot_strobe_frame_in;
	assign rx_idx = (!bp_mode && strobe && !stb_prev_r) ? '0 : cnt_r;
	assign rx_en = bp_mode ? (strobe && framed_r && cnt_r < CNT_WORD) : (strobe && rx_idx < CNT_WORD);

	always_comb
	begin
		stb_prev_nxt = strobe;
		rx_shift_nxt = rx_shift_r;
		rx_word_nxt = rx_word_r;
		done_tgl_nxt = done_tgl_r;
		framed_nxt = framed_r;
		cnt_nxt = (cnt_r != CNT_MAX) ? cnt_r + 1'b1 : cnt_r;
		if (bp_mode && !strobe && stb_prev_r)
		begin
			cnt_nxt = '0; // frame pulse: the bit after it is bit 0
			framed_nxt = 1'b1;
		end
		else if (!bp_mode && strobe && !stb_prev_r)
		begin
			cnt_nxt = CNT_W'(1);
			framed_nxt = 1'b1;
		end
		if (rx_en)
		begin
			rx_shift_nxt = {rx_shift_r[6:0], i_din};
			if (rx_idx == CNT_LAST)
			begin
				rx_word_nxt = {rx_shift_r[6:0], i_din};
				done_tgl_nxt = !done_tgl_r;
			end
		end
		if (bp_mode)
			dly_nxt = !(framed_nxt && cnt_nxt == CNT_DFP);
		else
			dly_nxt = framed_nxt && cnt_nxt >= CNT_DS0 && cnt_nxt <= CNT_DS1;
	end

	always_ff @(negedge i_link_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			cnt_r <= CNT_MAX;
			rx_shift_r <= 8'h00;
			rx_word_r <= 8'h00;
			done_tgl_r <= 1'b0;
			stb_prev_r <= 1'b0;
			framed_r <= 1'b0;
			dly_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			rx_shift_r <= rx_shift_nxt;
			rx_word_r <= rx_word_nxt;
			done_tgl_r <= done_tgl_nxt;
			stb_prev_r <= stb_prev_nxt;
			framed_r <= framed_nxt;
			dly_r <= dly_nxt;
		end
	end

	// transmit side on rising edges
	logic [CNT_W-1:0] tx_idx_r, tx_idx_nxt;
	logic tx_prev_r, tx_prev_nxt;
	logic dout_r, dout_nxt;
	logic dout_oe_r, dout_oe_nxt;
	logic [CNT_W-1:0] tx_bit;

	always_comb
	begin
		tx_prev_nxt = strobe;
		tx_idx_nxt = tx_idx_r;
		dout_nxt = dout_r;
		dout_oe_nxt = 1'b0;
		tx_bit = bp_mode ? cnt_r : ((strobe && !tx_prev_r) ? '0 : tx_idx_r);
		// the frame pulse still reads low at the edge of bit 0, so backplane timing follows the count only
		if (bp_mode ? (framed_r && cnt_r < CNT_WORD) : (strobe && tx_bit < CNT_WORD))
		begin
			dout_nxt = tx_hold_r[3'(CNT_LAST - tx_bit)];
			dout_oe_nxt = 1'b1;
		end
		if (!bp_mode && strobe && tx_bit != CNT_MAX)
			tx_idx_nxt = tx_bit + 1'b1;
	end

	always_ff @(posedge i_link_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			tx_idx_r <= CNT_MAX;
			tx_prev_r <= 1'b0;
			dout_r <= 1'b0;
			dout_oe_r <= 1'b0;
		end
		else
		begin
			tx_idx_r <= tx_idx_nxt;
			tx_prev_r <= tx_prev_nxt;
			dout_r <= dout_nxt;
			dout_oe_r <= dout_oe_nxt;
		end
	end

	assign o_dout = dout_r;
	assign o_dout_oe = dout_oe_r;
	assign o_delayed_strobe_out = dly_r;
endmodule

// >>> testbench/pvc_digital_port_assertions.sv
`timescale 1ns/100ps
module pvc_digital_port_assertions
(
	input wire logic i_sys_clk, // system clock
	input wire logic i_reset_n, // reset
	input wire logic i_link_clk, // link clock
	input wire logic i_slot_strobe_frame_in, // strobe
	input wire logic i_law_pin, // law pin
	input wire logic i_cs_n, // select
	input wire logic o_dout_oe, // tx enable
	input wire logic o_delayed_strobe_out, // cascade out
	input wire logic [7:0] o_rx_sample, // rx sample
	input wire logic o_rx_valid, // rx pulse
	input wire logic [2:0] o_tx_filter_gain, // tx gain
	input wire logic o_sidetone_en, // side-tone on
	input wire logic o_codec_power_up, // powered
	input wire logic o_a_law // a-law
);
	reset_defaults_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_reset_n) $rose(i_reset_n) |->
		o_codec_power_up && !o_sidetone_en && o_tx_filter_gain == 3'h0 && !o_a_law)
		else $error("reset defaults wrong");
	law_pin_or_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_reset_n) i_law_pin [*4] |-> o_a_law)
		else $error("law pin ignored");
	rx_pulse_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_reset_n) o_rx_valid |=> !o_rx_valid)
		else $error("rx valid too long");
	rx_hold_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_reset_n) !$stable(o_rx_sample) |-> o_rx_valid)
		else $error("rx sample changed without valid");
	tx_slot_width_a: assert property (
		@(posedge i_link_clk) disable iff (!i_reset_n) $rose(o_dout_oe) |-> o_dout_oe [*8] ##1 !o_dout_oe)
		else $error("tx enable not eight bits");
	cascade_strobe_a: assert property (
		@(posedge i_link_clk) disable iff (!i_reset_n)
		$rose(o_delayed_strobe_out) && !i_slot_strobe_frame_in && $past(i_slot_strobe_frame_in) |->
		o_delayed_strobe_out [*8] ##1 !o_delayed_strobe_out)
		else $error("cascade strobe not eight bits");
	frame_pulse_a: assert property (
		@(posedge i_link_clk) disable iff (!i_reset_n)
		$fell(o_delayed_strobe_out) && i_slot_strobe_frame_in |=> o_delayed_strobe_out)
		else $error("delayed frame pulse too long");
	cfg_by_port_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		$changed(o_tx_filter_gain) || $changed(o_sidetone_en) |-> !$past(i_cs_n, 2))
		else $error("gain changed without access");
endmodule

// >>> testbench/pvc_link_partner.sv
`timescale 1ns/100ps
module pvc_link_partner
(
	input wire logic i_link_clk, // bit clock
	input wire logic i_dout, // device tx data
	input wire logic i_dout_oe, // device tx enable
	output logic o_strobe, // strobe or frame pulse
	output logic o_din, // device rx data
	output logic [7:0] o_got, // last captured word
	output logic o_got_stb // toggles per word
);
	initial
	begin
		o_strobe = 1'b0;
		o_din = 1'b0;
		o_got = 8'h00;
		o_got_stb = 1'b0;
	end
	// one slot, strobe eight bits wide, msb first both ways
	task automatic slot(input logic [7:0] w);
		logic [7:0] cap;
		@(negedge i_link_clk);
		o_strobe <= 1'b1;
		for (int i = 7; i >= 0; i--)
		begin
			@(posedge i_link_clk);
			o_din <= w[i];
			@(negedge i_link_clk);
			cap[i] = (i_dout_oe === 1'b1) ? i_dout : 1'bx;
		end
		o_strobe <= 1'b0;
		o_din <= ~w[0]; // released line shows the inverse level
		o_got <= cap;
		o_got_stb <= ~o_got_stb;
	endtask
	task automatic set_idle(input logic lvl);
		@(posedge i_link_clk);
		o_strobe <= lvl;
	endtask
	// low for one bit period, seen on one falling edge
	task automatic frame_pulse();
		@(posedge i_link_clk);
		o_strobe <= 1'b0;
		@(posedge i_link_clk);
		o_strobe <= 1'b1;
	endtask
endmodule

// >>> testbench/pvc_digital_port_tb.sv
`timescale 1ns/100ps
module pvc_digital_port_tb;
	import pvc_pkg::*;
	logic sys_clk = 0, link_clk = 0, reset_n = 0, law_pin = 0, cs_n = 1, sclk = 0, data2 = 0, prev_ok = 1;
	logic [7:0] tx_sample = 8'h00, rd, prev = 8'h00, rx_sample, got;
	logic [8:0] txq[$], tx_e;
	logic [7:0] rxq[$];
	logic strobe, din, dout, dout_oe, dly, data1, data1_oe, rx_valid, st_en, pwr, a_law, got_stb, law_out, law_oe;
	logic [2:0] txg, rxg, stg;
	int err_total = 0, checked = 0, cycles = 0, seed = 32'hc14b, n;
	logic [7:0] tbl[4][4] = '{'{8'h80, 8'hff, 8'h7f, 8'h00}, '{8'haa, 8'hd5, 8'h55, 8'h2a},
		'{8'hff, 8'h80, 8'h00, 8'h7f}, '{8'haa, 8'hd5, 8'h55, 8'h2a}};
	logic [7:0] cfg[4] = '{8'h00, 8'h01, 8'h02, 8'h00};
	logic [7:0] msk[4] = '{PVC_MASK_MU, PVC_MASK_A, PVC_MASK_SMAG, PVC_MASK_A};
	logic [3:0] adr[4] = '{PVC_OFS_GAIN_ONE, PVC_OFS_GAIN_TWO, PVC_OFS_CODING, 4'h2};
	logic [7:0] wv[4] = '{8'h3d, 8'h0e, 8'h08, 8'ha5};
	logic [7:0] ev[4] = '{8'h3d, 8'h0e, 8'h08, 8'h00};
	always #20 sys_clk = ~sys_clk;
	initial
	begin
		#7;
		forever #80 link_clk = ~link_clk; // bit clock doubles as master clock
	end
	pvc_digital_port dut (.i_sys_clk(sys_clk), .i_reset_n(reset_n), .i_link_clk(link_clk),
		.i_slot_strobe_frame_in(strobe), .i_din(din), .o_dout(dout), .o_dout_oe(dout_oe),
		.o_delayed_strobe_out(dly), .i_law_pin(law_oe === 1'b1 ? law_out : law_pin), .o_law_pin_out(law_out),
		.o_law_pin_oe(law_oe), .i_cs_n(cs_n), .i_sclk(sclk), .i_data2(data2), .o_data1(data1),
		.o_data1_oe(data1_oe),
		.i_tx_sample(tx_sample), .o_rx_sample(rx_sample), .o_rx_valid(rx_valid), .o_tx_filter_gain(txg),
		.o_rx_filter_gain(rxg), .o_sidetone_gain(stg), .o_sidetone_en(st_en), .o_codec_power_up(pwr),
		.o_a_law(a_law));
	pvc_link_partner lp (.i_link_clk(link_clk), .i_dout(dout), .i_dout_oe(dout_oe), .o_strobe(strobe),
		.o_din(din), .o_got(got), .o_got_stb(got_stb));
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checked %0d, bad %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic mp(input logic rw, input logic [3:0] a, input logic [7:0] d);
		logic [15:0] sh;
		sh = {rw, 3'b000, a, d};
		cs_n = 1'b0;
		repeat (6) @(negedge sys_clk);
		for (int i = 15; i >= 0; i--)
		begin
			data2 = sh[i];
			repeat (6) @(negedge sys_clk);
			if (i < 8)
				rd[i] = data1;
			sclk = 1'b1;
			repeat (6) @(negedge sys_clk);
			sclk = 1'b0;
		end
		repeat (6) @(negedge sys_clk);
		cs_n = 1'b1;
		repeat (6) @(negedge sys_clk);
	endtask
	task automatic do_reset();
		@(negedge sys_clk);
		reset_n = 1'b0;
		repeat (8) @(negedge sys_clk);
		reset_n = 1'b1;
		prev = 8'h7f; // mu-law quiet code left to send after reset
		prev_ok = 1'b1;
		repeat (8) @(negedge sys_clk);
		chk("gain one out", 8'h00, {2'b00, rxg, txg});
		chk("gain two out", 8'h00, {4'h0, st_en, stg});
		chk("power and law", 8'h02, {6'h00, pwr, a_law});
		for (int k = 0; k < 3; k++)
		begin
			mp(1'b1, adr[k], 8'h00);
			chk("reset value", 8'h00, rd);
		end
		chk("pin drives", 8'h00, {5'h00, law_out, law_oe, data1_oe});
	endtask
	// tx word of the next slot is the sample handed in during this one
	task automatic frame(input logic [7:0] w, input logic [7:0] s, input logic [7:0] m);
		@(negedge sys_clk);
		tx_sample = s;
		rxq.push_back(w ^ m);
		txq.push_back(prev_ok ? {1'b0, prev} : 9'h100);
		lp.slot(w);
		prev = s ^ m;
		prev_ok = 1'b1;
		repeat (48) @(negedge sys_clk);
	endtask
	always @(negedge sys_clk)
		if (rx_valid === 1'b1 && rxq.size() > 0)
			chk("rx sample", rxq.pop_front(), rx_sample);
	always @(got_stb)
	begin
		#1;
		if (txq.size() > 0)
		begin
			tx_e = txq.pop_front();
			if (!tx_e[8])
				chk("tx word", tx_e[7:0], got);
		end
	end
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_total++;
			$display("BAD run length expected finish seen hang");
			give_verdict();
		end
	end
	initial
	begin
		do_reset();
		for (int k = 0; k < 4; k++)
			mp(1'b0, adr[k], wv[k]);
		for (int k = 0; k < 4; k++)
		begin
			mp(1'b1, adr[k], 8'h00);
			chk("register readback", ev[k], rd);
		end
		chk("gain one out", 8'h3d, {2'b00, rxg, txg});
		chk("gain two out", 8'h0e, {4'h0, st_en, stg});
		chk("power and law", 8'h00, {6'h00, pwr, a_law});
		$display("test registers done");
		do_reset();
		frame(8'h7f, 8'h00, PVC_MASK_MU);
		$display("test reset done");
		for (int md = 0; md < 4; md++)
		begin
			mp(1'b0, PVC_OFS_CODING, cfg[md]);
			law_pin = (md == 3);
			repeat (8) @(negedge sys_clk);
			chk("a-law", {7'h00, md == 1 || md == 3}, {7'h00, a_law});
			prev_ok = 1'b0;
			for (int i = 0; i < 5; i++)
				frame(tbl[md][i % 4], tbl[2][i % 4], msk[md]);
		end
		law_pin = 1'b0;
		mp(1'b0, PVC_OFS_CODING, 8'h00);
		prev_ok = 1'b0;
		repeat (6)
			frame(8'($random(seed)), 8'($random(seed)), PVC_MASK_MU);
		$display("test link done");
		mp(1'b0, PVC_OFS_CODING, 8'h04);
		repeat (4) @(posedge link_clk);
		lp.set_idle(1'b1);
		repeat (40) @(posedge link_clk);
		lp.frame_pulse();
		n = 0;
		while (dly !== 1'b0 && n < 40)
		begin
			@(posedge link_clk);
			n++;
		end
		chk("pulse delay", 8'h01, {7'h00, n >= 30 && n <= 33});
		@(posedge link_clk);
		chk("pulse width", 8'h01, {7'h00, dly});
		$display("test backplane done");
		give_verdict();
	end
endmodule
bind pvc_digital_port pvc_digital_port_assertions chk_i (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
	.i_link_clk(i_link_clk), .i_slot_strobe_frame_in(i_slot_strobe_frame_in), .i_law_pin(i_law_pin),
	.i_cs_n(i_cs_n), .o_dout_oe(o_dout_oe), .o_delayed_strobe_out(o_delayed_strobe_out),
	.o_rx_sample(o_rx_sample), .o_rx_valid(o_rx_valid), .o_tx_filter_gain(o_tx_filter_gain),
	.o_sidetone_en(o_sidetone_en), .o_codec_power_up(o_codec_power_up), .o_a_law(o_a_law));
